// File: power_loss_stop_consts.vh
// constants for the main power loss stop sequencer
`ifndef POWER_LOSS_STOP_CONSTS_VH
`define POWER_LOSS_STOP_CONSTS_VH

// register byte offsets
`define OFF_SEQ_CTRL        8'h00
`define OFF_DETECT_TIME     8'h04
`define OFF_WARN_DELAY      8'h08
`define OFF_ESTOP_TORQUE    8'h0c
`define OFF_BRAKE_EN        8'h10
`define OFF_ALARM_CLEAR     8'h14
`define OFF_STATUS          8'h18
`define OFF_INT_STATUS      8'h1c
`define OFF_INT_MASK        8'h20

// sequence control fields
`define SEQ_LSB             0
`define SEQ_MSB             3
`define TRIP_AC_BIT         4
`define TRIP_WARN_BIT       5

// interrupt status bits
`define INT_POWER_LOST      0
`define INT_WARNING         1
`define INT_AC_ALARM        2
`define INT_DC_ALARM        3
`define INT_STOPPED         4
`define INT_W               5

// reset values
`define RST_SEQ             4'h0
`define RST_TRIP            2'h0
`define RST_DETECT_MS       11'h046
`define RST_WARN_MS         11'h000
`define RST_ESTOP_TORQUE    9'h000

// limits
`define DETECT_MIN_MS       11'h014
`define DETECT_OFF_MS       11'h7d0
`define TORQUE_MAX_PCT      9'h1f4
`define STOP_SPEED_RPM      16'h001e
`define SEQ_MAX_CODE        4'h9

// timing
`define CLK_PERIOD_NS       8
`define MS_IN_NS            1000000

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: elapsed_ms_timer.v
// millisecond timer that flags when a condition has lasted past a limit
`timescale 1ns/1ps
`default_nettype none

module elapsed_ms_timer #(
    parameter CNT_W  = 11,
    parameter STRICT = 0
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             run,
    input  wire             msTick,
    input  wire [CNT_W-1:0] limit,
    output reg              expired_ff
);
    reg [CNT_W-1:0] count_ff;
    wire            atTop = &count_ff;
    wire            passed = STRICT ? (count_ff > limit) : (count_ff >= limit);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff   <= {CNT_W{1'b0}};
            expired_ff <= 1'b0;
        end else if (!run) begin
            count_ff   <= {CNT_W{1'b0}};
            expired_ff <= 1'b0;
        end else begin
            // saturate so a long outage never wraps back to zero
            if (msTick && !atTop)
                count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            expired_ff <= passed;
        end
    end
endmodule // elapsed_ms_timer

`default_nettype wire

// File: power_loss_stop_sequencer.v
// main power loss stop sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "power_loss_stop_consts.vh"

//Contract
// RULE1: stop sequence selector takes codes 0 to 9
// RULE2: trip bit clear: servo-off, resume on return
// RULE3: trip bit set: raise AC undervoltage alarm
// RULE4: no AC alarm while retracting
// RULE5: warning only after loss outlasts warning delay
// RULE6: warn bit: servo-on only, or always
// RULE7: detect time 20..2000 ms, 2000 disables
// RULE8: estop torque 0..500, zero uses normal
// RULE9: brake input enable, only while power off
// RULE10: codes map decel and post-stop, clear deviation
// RULE11: decel ends at 30 rpm or less
// RULE12: host keeps commands 4 ms after loss
// RULE13: brake input ignored when servo-on, trip, safety
module power_loss_stop_sequencer #(
    parameter CYCLES_PER_MS = `MS_IN_NS / `CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        mainPowerOk,
    input  wire        servoOnCmd,
    input  wire [15:0] motorSpeedRpm,
    input  wire        brakeSelectInput,
    input  wire        tripActive,
    input  wire        safetyState,
    input  wire        retractActive,
    input  wire        dcBusUndervoltageAlarm,
    input  wire [8:0]  normalTorqueLimit,
    output reg         servoEnable_ff,
    output reg         dynamicBrake_ff,
    output reg         estopActive_ff,
    output reg  [8:0]  torqueLimit_ff,
    output reg         clearDeviation_ff,
    output reg         acInterruptUndervoltageAlarm_ff,
    output reg         powerOffWarning_ff,
    output reg         irq_ff
);
    localparam ST_RUN  = 3'b001;
    localparam ST_DEC  = 3'b010;
    localparam ST_HOLD = 3'b100;

    function [31:0] mergeStrb;
        input [31:0] old;
        input [31:0] val;
        input [3:0]  strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                mergeStrb[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // software settings
    reg [3:0]  powerLossStopSequence_ff;
    reg [1:0]  lowVoltageTripSelect_ff;
    reg [10:0] powerLossDetectTime_ff;
    reg [10:0] powerLossWarningDelay_ff;
    reg [8:0]  estopTorqueLimit_ff;
    reg        brakeInputEnable_ff;
    reg [`INT_W-1:0] intStatus_ff;
    reg [`INT_W-1:0] intMask_ff;

    // bus channel state
    reg        awHave_ff;
    reg        wHave_ff;
    reg [7:0]  awAddr_ff;
    reg [31:0] wData_ff;
    reg [3:0]  wStrb_ff;

    // sequencer state
    reg [2:0]  state_ff;
    reg        powerLost_ff;
    reg        dcAlarmSeen_ff;
    reg        alarmClear_ff;
    reg [16:0] tickCnt_ff;
    reg        msTick_ff;

    wire       detectExpired;
    wire       warnExpired;
    wire [10:0] detectLimit = (powerLossDetectTime_ff < `DETECT_MIN_MS) ?
                              `DETECT_MIN_MS : powerLossDetectTime_ff;
    wire       detectOff = powerLossDetectTime_ff >= `DETECT_OFF_MS; // see RULE7
    wire       powerLostNow = detectExpired && !detectOff;
    wire       warnRun = !mainPowerOk &&
                         (lowVoltageTripSelect_ff[1] || servoOnCmd); // see RULE6
    wire       tripOnLoss = lowVoltageTripSelect_ff[0];
    wire       slowEnough = motorSpeedRpm <= `STOP_SPEED_RPM; // see RULE11
    wire [3:0] seqCode = (powerLossStopSequence_ff > `SEQ_MAX_CODE) ?
                         4'h0 : powerLossStopSequence_ff; // see RULE1
    wire       seqEstop = seqCode[3];
    // decel: even codes brake, odd codes run free; 8/9 use estop instead
    wire       decelBrake = !seqEstop && !seqCode[0]; // see RULE10
    wire       holdBrake = seqEstop ? !seqCode[0] : !seqCode[1]; // see RULE10
    // brake input honoured only while power off, no trip, no safety, servo off
    wire       brakeInputLive = brakeInputEnable_ff && !mainPowerOk && !tripActive &&
                                !safetyState && !servoOnCmd; // see RULE9 see RULE13
    wire       awFire = s_axi_awvalid && s_axi_awready;
    wire       wFire = s_axi_wvalid && s_axi_wready;
    wire       arFire = s_axi_arvalid && s_axi_arready;
    wire       doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;
    wire [31:0] wMerged = mergeStrb(32'h0, wData_ff, wStrb_ff);
    wire [31:0] detMerged = mergeStrb({21'h0, powerLossDetectTime_ff}, wData_ff, wStrb_ff);
    wire [31:0] warnMerged = mergeStrb({21'h0, powerLossWarningDelay_ff}, wData_ff, wStrb_ff);
    wire [31:0] torqMerged = mergeStrb({23'h0, estopTorqueLimit_ff}, wData_ff, wStrb_ff);
    wire       lossRise = powerLostNow && !powerLost_ff;
    wire       readIntStatus = arFire && (s_axi_araddr == `OFF_INT_STATUS);

    elapsed_ms_timer #(.CNT_W(11), .STRICT(0)) detectTimer (
        .clk        (clk),
        .rst_b      (rst_b),
        .run        (!mainPowerOk),
        .msTick     (msTick_ff),
        .limit      (detectLimit),
        .expired_ff (detectExpired)
    );

    // strict compare: warning needs the outage to last longer than the delay
    elapsed_ms_timer #(.CNT_W(11), .STRICT(1)) warnTimer (
        .clk        (clk),
        .rst_b      (rst_b),
        .run        (warnRun),
        .msTick     (msTick_ff),
        .limit      (powerLossWarningDelay_ff),
        .expired_ff (warnExpired)
    );

    // millisecond tick
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_ff <= 17'h00000;
            msTick_ff  <= 1'b0;
        end else if (tickCnt_ff >= CYCLES_PER_MS - 1) begin
            tickCnt_ff <= 17'h00000;
            msTick_ff  <= 1'b1;
        end else begin
            tickCnt_ff <= tickCnt_ff + 17'h00001;
            msTick_ff  <= 1'b0;
        end
    end

    // write channel
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready            <= 1'b1;
            s_axi_wready             <= 1'b1;
            s_axi_bvalid             <= 1'b0;
            s_axi_bresp              <= `RESP_OKAY;
            awHave_ff                <= 1'b0;
            wHave_ff                 <= 1'b0;
            awAddr_ff                <= 8'h00;
            wData_ff                 <= 32'h00000000;
            wStrb_ff                 <= 4'h0;
            powerLossStopSequence_ff <= `RST_SEQ;
            lowVoltageTripSelect_ff  <= `RST_TRIP;
            powerLossDetectTime_ff   <= `RST_DETECT_MS;
            powerLossWarningDelay_ff <= `RST_WARN_MS;
            estopTorqueLimit_ff      <= `RST_ESTOP_TORQUE;
            brakeInputEnable_ff      <= 1'b0;
            intMask_ff               <= {`INT_W{1'b0}};
            alarmClear_ff            <= 1'b0;
        end else begin
            alarmClear_ff <= 1'b0;
            if (awFire) begin
                awAddr_ff     <= s_axi_awaddr;
                awHave_ff     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (wFire) begin
                wData_ff     <= s_axi_wdata;
                wStrb_ff     <= s_axi_wstrb;
                wHave_ff     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (awAddr_ff)
                    `OFF_SEQ_CTRL: begin
                        if (wStrb_ff[0]) begin
                            powerLossStopSequence_ff <= wMerged[`SEQ_MSB:`SEQ_LSB];
                            lowVoltageTripSelect_ff  <= wMerged[`TRIP_WARN_BIT:`TRIP_AC_BIT];
                        end
                    end
                    `OFF_DETECT_TIME: begin
                        powerLossDetectTime_ff <= detMerged[10:0];
                    end
                    `OFF_WARN_DELAY: begin
                        powerLossWarningDelay_ff <= warnMerged[10:0];
                    end
                    `OFF_ESTOP_TORQUE: begin
                        // values above the range are clamped to the top
                        if (torqMerged > {23'h0, `TORQUE_MAX_PCT})
                            estopTorqueLimit_ff <= `TORQUE_MAX_PCT;
                        else
                            estopTorqueLimit_ff <= torqMerged[8:0];
                    end
                    `OFF_BRAKE_EN: begin
                        if (wStrb_ff[0])
                            brakeInputEnable_ff <= wData_ff[0];
                    end
                    `OFF_ALARM_CLEAR: begin
                        if (wStrb_ff[0])
                            alarmClear_ff <= wData_ff[0];
                    end
                    `OFF_INT_MASK: begin
                        if (wStrb_ff[0])
                            intMask_ff <= wData_ff[`INT_W-1:0];
                    end
                    `OFF_STATUS, `OFF_INT_STATUS: begin
                        s_axi_bresp <= `RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                awHave_ff     <= 1'b0;
                wHave_ff      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (arFire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `RESP_OKAY;
                case (s_axi_araddr)
                    `OFF_SEQ_CTRL:     s_axi_rdata <= {26'h0, lowVoltageTripSelect_ff,
                                                       powerLossStopSequence_ff};
                    `OFF_DETECT_TIME:  s_axi_rdata <= {21'h0, powerLossDetectTime_ff};
                    `OFF_WARN_DELAY:   s_axi_rdata <= {21'h0, powerLossWarningDelay_ff};
                    `OFF_ESTOP_TORQUE: s_axi_rdata <= {23'h0, estopTorqueLimit_ff};
                    `OFF_BRAKE_EN:     s_axi_rdata <= {31'h0, brakeInputEnable_ff};
                    `OFF_ALARM_CLEAR:  s_axi_rdata <= 32'h00000000;
                    `OFF_STATUS:       s_axi_rdata <= {22'h0, state_ff, powerLost_ff,
                                           powerOffWarning_ff, acInterruptUndervoltageAlarm_ff,
                                           servoEnable_ff, dynamicBrake_ff, estopActive_ff,
                                           clearDeviation_ff};
                    `OFF_INT_STATUS:   s_axi_rdata <= {{(32-`INT_W){1'b0}}, intStatus_ff};
                    `OFF_INT_MASK:     s_axi_rdata <= {{(32-`INT_W){1'b0}}, intMask_ff};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // stop sequence and outputs
    reg [2:0] nxt_state;
    reg [`INT_W-1:0] events;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (powerLostNow && !tripOnLoss)
                    nxt_state = ST_DEC; // see RULE2
            end
            ST_DEC: begin
                if (slowEnough)
                    nxt_state = ST_HOLD; // see RULE11
            end
            ST_HOLD: begin
                // speed is no longer looked at once stopped
                if (mainPowerOk)
                    nxt_state = ST_RUN; // see RULE2
            end
            default: nxt_state = ST_RUN;
        endcase
        events = {`INT_W{1'b0}};
        events[`INT_POWER_LOST] = lossRise;
        events[`INT_WARNING]    = warnExpired && !powerOffWarning_ff;
        events[`INT_AC_ALARM]   = lossRise && tripOnLoss && !retractActive;
        events[`INT_DC_ALARM]   = dcBusUndervoltageAlarm && !dcAlarmSeen_ff;
        events[`INT_STOPPED]    = (state_ff == ST_DEC) && (nxt_state == ST_HOLD);
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff                        <= ST_RUN;
            powerLost_ff                    <= 1'b0;
            dcAlarmSeen_ff                  <= 1'b0;
            intStatus_ff                    <= {`INT_W{1'b0}};
            servoEnable_ff                  <= 1'b0;
            dynamicBrake_ff                 <= 1'b0;
            estopActive_ff                  <= 1'b0;
            torqueLimit_ff                  <= 9'h000;
            clearDeviation_ff               <= 1'b0;
            acInterruptUndervoltageAlarm_ff <= 1'b0;
            powerOffWarning_ff              <= 1'b0;
            irq_ff                          <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            powerLost_ff   <= powerLostNow;
            dcAlarmSeen_ff <= dcBusUndervoltageAlarm;
            // a new event in the read cycle survives the clear
            intStatus_ff <= (readIntStatus ? {`INT_W{1'b0}} : intStatus_ff) | events;
            irq_ff <= |(((readIntStatus ? {`INT_W{1'b0}} : intStatus_ff) | events) & intMask_ff);
            powerOffWarning_ff <= warnExpired; // see RULE5
            // retraction suppresses the trip; the DC bus alarm is reported regardless
            if (events[`INT_AC_ALARM])
                acInterruptUndervoltageAlarm_ff <= 1'b1; // see RULE3 see RULE4
            else if (alarmClear_ff && mainPowerOk)
                acInterruptUndervoltageAlarm_ff <= 1'b0;
            // estop keeps the servo energised while it decelerates
            estopActive_ff <= (nxt_state == ST_DEC) && seqEstop; // see RULE10
            servoEnable_ff <= ((nxt_state == ST_RUN) && servoOnCmd &&
                               !acInterruptUndervoltageAlarm_ff && !events[`INT_AC_ALARM]) ||
                              ((nxt_state == ST_DEC) && seqEstop);
            clearDeviation_ff <= (nxt_state != ST_RUN); // see RULE10
            // the host must keep commanding for a while so this limit takes hold
            if ((nxt_state == ST_DEC) && seqEstop && (estopTorqueLimit_ff != 9'h000))
                torqueLimit_ff <= estopTorqueLimit_ff; // see RULE8 see RULE12
            else
                torqueLimit_ff <= normalTorqueLimit; // see RULE8
            case (nxt_state)
                ST_DEC:  dynamicBrake_ff <= brakeInputLive ? !brakeSelectInput : decelBrake;
                ST_HOLD: dynamicBrake_ff <= brakeInputLive ? !brakeSelectInput : holdBrake;
                default: dynamicBrake_ff <= 1'b0;
            endcase
        end
    end
endmodule // power_loss_stop_sequencer

`default_nettype wire

// File: power_loss_stop_props.sv
// port checker for the power loss stop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_loss_stop_consts.vh"
module power_loss_stop_props (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        mainPowerOk,
    input wire logic        retractActive,
    input wire logic [15:0] motorSpeedRpm,
    input wire logic        estopActive_ff,
    input wire logic        clearDeviation_ff,
    input wire logic        acInterruptUndervoltageAlarm_ff,
    input wire logic        powerOffWarning_ff
);
    wire logic acAlarm = acInterruptUndervoltageAlarm_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence sWrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sAcRise;
        $rose(acAlarm);
    endsequence
    AST_WR_ANSWER: assert property (sWrTaken |-> ##[1:2] s_axi_bvalid)
        else $error("no bresp");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rdata");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    AST_AC_CAUSE: assert property (sAcRise |-> !$past(mainPowerOk))
        else $error("alarm, power ok");
    AST_AC_RETRACT: assert property (sAcRise |-> !$past(retractActive))
        else $error("alarm in retract");
    AST_AC_STICKY: assert property ($fell(acAlarm) |-> $past(mainPowerOk))
        else $error("alarm cleared early");
    AST_WARN_CAUSE: assert property ($rose(powerOffWarning_ff) |-> !$past(mainPowerOk))
        else $error("warning, power ok");
    AST_DECEL_END: assert property (estopActive_ff && motorSpeedRpm <= `STOP_SPEED_RPM
        |-> ##[1:3] !estopActive_ff)
        else $error("decel not ended");
    AST_ESTOP_CLR: assert property (estopActive_ff |-> clearDeviation_ff)
        else $error("deviation kept");
endmodule // power_loss_stop_props
bind power_loss_stop_sequencer power_loss_stop_props i_props (.*);
`default_nettype wire

// File: host_motion_model.sv
// host motion controller model driving the servo command
`timescale 1ns/1ps
`default_nettype none
module host_motion_model #(
    parameter int HOLD_CYCLES = 40
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic wantOn,
    input  wire logic lossSeen,
    output var  logic servoOnCmd
);
    logic [15:0] holdCnt_ff;
    logic        seen_ff;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_ff <= 16'h0000;
            seen_ff    <= 1'b0;
        end else begin
            seen_ff <= lossSeen;
            if (lossSeen && !seen_ff && servoOnCmd)
                holdCnt_ff <= 16'(HOLD_CYCLES);
            else if (holdCnt_ff != 16'h0000)
                holdCnt_ff <= holdCnt_ff - 16'h0001;
        end
    end
    assign servoOnCmd = wantOn || (holdCnt_ff != 16'h0000);
endmodule // host_motion_model
`default_nettype wire

// File: test_power_loss_stop_sequencer.sv
// self-checking bench for the power loss stop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_loss_stop_consts.vh"
module test_power_loss_stop_sequencer;
    localparam int CPM = 10;
    logic        clk, rst_b = 1'b0, wantOn = 1'b1, servoOnCmd;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, mainPowerOk = 1'b1;
    logic        brakeSelectInput = 1'b1, tripActive = 1'b0, safetyState = 1'b0;
    logic        retractActive = 1'b0, dcBusUndervoltageAlarm = 1'b0;
    logic [15:0] motorSpeedRpm = 16'h0000;
    logic [8:0]  normalTorqueLimit = 9'h064, torqueLimit_ff;
    logic        servoEnable_ff, dynamicBrake_ff, estopActive_ff, clearDeviation_ff;
    logic        acInterruptUndervoltageAlarm_ff, powerOffWarning_ff, irq_ff;
    logic [33:0] expQ[$];
    int          fail_count, tests_run, seed, i, n, code;

    power_loss_stop_sequencer #(.CYCLES_PER_MS(CPM)) i_dut (.*);
    host_motion_model #(.HOLD_CYCLES(4 * CPM)) i_host (.lossSeen(clearDeviation_ff), .*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            check("wait bound", 34'h0, 34'h1);
            print_verdict();
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (n = 1; n < 60; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr ? s_axi_bvalid : s_axi_rvalid) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        guard(n < 60);
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        axi(1'b1, a, d);
    endtask

    task automatic axiRead(input logic [7:0] a, input logic [33:0] e);
        expQ.push_back(e);
        axi(1'b0, a, 32'h0);
    endtask

    always @(posedge clk)
        if (s_axi_rvalid && s_axi_rready)
            check("read", {s_axi_rresp, s_axi_rdata}, expQ.pop_front());

    initial begin
        seed = 86;
        normalTorqueLimit <= 9'h064 + 9'($random(seed) & 32'hff);
        tick(3);
        rst_b <= 1'b1;
        axiRead(`OFF_SEQ_CTRL, 34'h0);
        axiRead(`OFF_DETECT_TIME, 34'h046);
        axiRead(8'h24, 34'h200000000);
        axiWrite(`OFF_DETECT_TIME, 32'h14);
        axiWrite(`OFF_WARN_DELAY, 32'h5);
        axiWrite(`OFF_ESTOP_TORQUE, 32'h258);
        axiWrite(`OFF_INT_MASK, 32'h1f);
        axiRead(`OFF_ESTOP_TORQUE, 34'h1f4);
        for (code = 0; code < 10; code++) begin
            if (code == 9) axiWrite(`OFF_ESTOP_TORQUE, 32'h0);
            axiWrite(`OFF_SEQ_CTRL, 32'(code));
            motorSpeedRpm <= 16'h001f + 16'($random(seed) & 32'h3ff);
            mainPowerOk <= 1'b0;
            tick(3 * CPM);
            check("early warning", powerOffWarning_ff, 1'b0);
            for (i = 0; i < 400 && clearDeviation_ff !== 1'b1; i++) @(posedge clk);
            guard(i < 400);
            check("decel brake", dynamicBrake_ff, code < 8 && code % 2 == 0);
            check("estop", estopActive_ff, code >= 8);
            if (code >= 8)
                check("torque", torqueLimit_ff, code == 9 ? normalTorqueLimit : 9'h1f4);
            motorSpeedRpm <= `STOP_SPEED_RPM;
            tick(5);
            check("post brake", dynamicBrake_ff, code == 8 || code < 8 && code % 4 < 2);
            check("irq", irq_ff, 1'b1);
            mainPowerOk <= 1'b1;
            for (i = 0; i < 50 && servoEnable_ff !== 1'b1; i++) @(posedge clk);
            guard(i < 50);
            axiRead(`OFF_INT_STATUS, 34'h13);
            tick(2);
            check("irq clear", irq_ff, 1'b0);
        end
        axiWrite(`OFF_SEQ_CTRL, 32'h10);
        retractActive <= 1'b1;
        mainPowerOk <= 1'b0;
        tick(40 * CPM);
        check("alarm retract", acInterruptUndervoltageAlarm_ff, 1'b0);
        mainPowerOk <= 1'b1;
        retractActive <= 1'b0;
        tick(5);
        mainPowerOk <= 1'b0;
        for (i = 0; i < 400 && acInterruptUndervoltageAlarm_ff !== 1'b1; i++) @(posedge clk);
        guard(i < 400);
        check("servo tripped", servoEnable_ff, 1'b0);
        mainPowerOk <= 1'b1;
        tick(5);
        check("alarm sticky", acInterruptUndervoltageAlarm_ff, 1'b1);
        axiWrite(`OFF_ALARM_CLEAR, 32'h1);
        tick(3);
        check("alarm cleared", acInterruptUndervoltageAlarm_ff, 1'b0);
        wantOn <= 1'b0;
        axiWrite(`OFF_DETECT_TIME, 32'h7d0);
        axiWrite(`OFF_SEQ_CTRL, 32'h0);
        mainPowerOk <= 1'b0;
        tick(30 * CPM);
        check("detect off", clearDeviation_ff, 1'b0);
        check("warn servo off", powerOffWarning_ff, 1'b0);
        axiWrite(`OFF_SEQ_CTRL, 32'h20);
        for (i = 0; i < 200 && powerOffWarning_ff !== 1'b1; i++) @(posedge clk);
        guard(i < 200);
        mainPowerOk <= 1'b1;
        axiWrite(`OFF_DETECT_TIME, 32'h14);
        axiWrite(`OFF_BRAKE_EN, 32'h1);
        axiWrite(`OFF_SEQ_CTRL, 32'h3);
        brakeSelectInput <= 1'b0;
        tick(5);
        check("brake power on", dynamicBrake_ff, 1'b0);
        mainPowerOk <= 1'b0;
        tick(30 * CPM);
        check("brake input", dynamicBrake_ff, 1'b1);
        brakeSelectInput <= 1'b1;
        tick(3);
        check("brake released", dynamicBrake_ff, 1'b0);
        brakeSelectInput <= 1'b0;
        safetyState <= 1'b1;
        tick(3);
        check("brake safety", dynamicBrake_ff, 1'b0);
        print_verdict();
    end
endmodule // test_power_loss_stop_sequencer
`default_nettype wire
